// ---- design/tlvi_defines.svh ----
// Constants for the two-level vectored interrupt unit
`ifndef TLVI_DEFINES_SVH
`define TLVI_DEFINES_SVH

`define TLVI_NUM_SRC 23
`define TLVI_RESET_VEC 16'h0000
`define TLVI_VEC_BASE 16'h0003
`define TLVI_VEC_STEP 16'h0008
`define TLVI_BASE_BITS 7
`define TLVI_EXT1_FIRST 7
`define TLVI_EXT2_FIRST 15
`define TLVI_GLOBAL_BIT 7
`define TLVI_IRQ_BASE_REG_OFS 8'h00
`define TLVI_IRQ_ENABLE_EXT_ONE_OFS 8'h01
`define TLVI_IRQ_ENABLE_EXT_TWO_OFS 8'h02
`define TLVI_IRQ_PRIORITY_BASE_OFS 8'h03
`define TLVI_IRQ_PRIORITY_EXT_ONE_OFS 8'h04
`define TLVI_IRQ_PRIORITY_EXT_TWO_OFS 8'h05
`define TLVI_STATUS_OFS 8'h06
`define TLVI_FLAG_LO_OFS 8'h07
`define TLVI_FLAG_MID_OFS 8'h08
`define TLVI_FLAG_HI_OFS 8'h09
`define TLVI_ENABLE_RESET 8'h00
`define TLVI_PRIORITY_RESET 8'h00
`define TLVI_PRIO_BASE_UNUSED 8'h80
`define TLVI_HW_CLEAR_MASK 23'h01000F
`define TLVI_DETECT_CYCLES 1
`define TLVI_CALL_CYCLES 4
`define TLVI_FLAGLESS_MASK 23'h028000

`endif

// ---- design/tlvi_pkg.sv ----
// Types for the two-level vectored interrupt unit
package tlvi_pkg;

    typedef enum logic [1:0] {
        TLVI_IDLE = 2'b00,
        TLVI_CALL = 2'b01,
        TLVI_WAIT_INSN = 2'b10
    } tlvi_state_e;

    typedef logic [4:0] tlvi_idx_t;

endpackage

// ---- design/tlvi_unit.sv ----
// Two-level vectored interrupt unit with register port and core handshake
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "tlvi_defines.svh"

// Operation
// - Twenty-three sources, each with its own vector, besides reset.
// - A flag set by software requests exactly like a hardware event.
// - High-priority request preempts a running low-priority routine.
// - A running high-priority routine is never preempted.
// - All priorities are low after reset.
// - High level wins; ties go to lowest order number.
// - Requests sampled and decoded every clock cycle.
// - One detect cycle, then call issued; four-cycle call completes it.
// - After a return with request pending, one instruction completes before the call.
// - Worst case eighteen clocks follows from detect plus core timing.
// - Equal or lower level waits for return plus one instruction.
// - Vector is 0x0003 plus eight times order; reset vector 0x0000.
// - Enables split over base bits 0-6, ext one and ext two.
// - Priority bits mirror the enable bit positions.
// - Hardware clears only external, timer 0/1 and CAN flags on vectoring.
// - Regulator dropout and port match request without visible flag.
// - Global enable low blocks every source.
// - Flags set regardless of enables; disabled ones are ignored.
// - A flag still set after return re-requests once the next instruction completes.
// - A source with several flags requests while any is set.
module tlvi_unit
    import tlvi_pkg::*;
#(
    parameter int NSRC = `TLVI_NUM_SRC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Peripheral events, one bit per source (any of its flags)
    input wire logic [NSRC-1:0] src_event,
    // Flagless sources give live levels here
    input wire logic [NSRC-1:0] src_level,
    // Core sequencer
    input wire logic call_ack,
    input wire logic return_from_irq,
    input wire logic insn_done,
    output logic call_req,
    output logic [15:0] call_vector,
    output logic [NSRC-1:0] hw_flag_clear
);

    logic [7:0] irq_enable_base_reg_q;
    logic [7:0] irq_enable_ext_one_q;
    logic [7:0] irq_enable_ext_two_q;
    logic [7:0] irq_priority_base_reg_q;
    logic [7:0] irq_priority_ext_one_q;
    logic [7:0] irq_priority_ext_two_q;
    logic [NSRC-1:0] flag_q;
    logic [NSRC-1:0] flag_d;
    logic [NSRC-1:0] sw_set;
    logic [NSRC-1:0] sw_clr;
    logic [NSRC-1:0] enables;
    logic [NSRC-1:0] prios;
    logic [NSRC-1:0] active;
    logic [NSRC-1:0] eligible;
    logic in_low_q;
    logic in_high_q;
    tlvi_state_e state_q;
    logic win_valid;
    tlvi_idx_t win_idx;
    logic win_high;
    logic [7:0] rdata_d;
    logic [NSRC-1:0] hw_clr;
    // Winner frozen at call time; live arbitration may move before the ack
    tlvi_idx_t call_idx_q;
    logic call_high_q;

    // Order number to vector address
    function automatic logic [15:0] vec_of(input tlvi_idx_t idx);
        vec_of = `TLVI_VEC_BASE + (16'(idx) << 3);
    endfunction

    // Place a register byte over the flat source vector
    function automatic logic [NSRC-1:0] spread(input logic [7:0] b0, input logic [7:0] b1,
                                               input logic [7:0] b2);
        spread = {b2, b1, b0[`TLVI_BASE_BITS-1:0]};
    endfunction

    assign enables = spread(irq_enable_base_reg_q, irq_enable_ext_one_q, irq_enable_ext_two_q);
    assign prios = spread(irq_priority_base_reg_q, irq_priority_ext_one_q,
                          irq_priority_ext_two_q);

    // Flagless sources follow their live level; others use the latched flag
    assign active = (flag_q & ~`TLVI_FLAGLESS_MASK)
                  | (src_level & `TLVI_FLAGLESS_MASK);
    assign eligible = active & enables
                    & {NSRC{irq_enable_base_reg_q[`TLVI_GLOBAL_BIT]}};

    // Fixed-order arbitration within the winning level
    always_comb
    begin
        logic any_high;
        any_high = |(eligible & prios);
        win_valid = 1'b0;
        win_idx = '0;
        win_high = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (eligible[i] && (prios[i] || !any_high))
            begin
                win_valid = 1'b1;
                win_idx = tlvi_idx_t'(i);
                win_high = prios[i];
            end
        end
        // Level gate: nothing preempts high, only high preempts low
        if (in_high_q || (in_low_q && !win_high))
        begin
            win_valid = 1'b0;
        end
    end

    // Software writes to the flag registers
    always_comb
    begin
        sw_set = '0;
        sw_clr = '0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `TLVI_FLAG_LO_OFS:
                begin
                    sw_set[7:0] = reg_wdata;
                    sw_clr[7:0] = ~reg_wdata;
                end
                `TLVI_FLAG_MID_OFS:
                begin
                    sw_set[15:8] = reg_wdata;
                    sw_clr[15:8] = ~reg_wdata;
                end
                `TLVI_FLAG_HI_OFS:
                begin
                    sw_set[NSRC-1:16] = reg_wdata[NSRC-17:0];
                    sw_clr[NSRC-1:16] = ~reg_wdata[NSRC-17:0];
                end
                default:
                begin
                    sw_set = '0;
                end
            endcase
        end
    end

    // Hardware set wins over any clear in the same cycle
    always_comb
    begin
        hw_clr = '0;
        if (state_q == TLVI_CALL && call_ack)
        begin
            hw_clr[call_idx_q] = 1'b1;
        end
        hw_clr = hw_clr & `TLVI_HW_CLEAR_MASK;
        flag_d = ((flag_q & ~sw_clr & ~hw_clr) | sw_set | src_event);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_enable_base_reg_q <= `TLVI_ENABLE_RESET;
            irq_enable_ext_one_q <= `TLVI_ENABLE_RESET;
            irq_enable_ext_two_q <= `TLVI_ENABLE_RESET;
            irq_priority_base_reg_q <= `TLVI_PRIORITY_RESET;
            irq_priority_ext_one_q <= `TLVI_PRIORITY_RESET;
            irq_priority_ext_two_q <= `TLVI_PRIORITY_RESET;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `TLVI_IRQ_BASE_REG_OFS: irq_enable_base_reg_q <= reg_wdata;
                `TLVI_IRQ_ENABLE_EXT_ONE_OFS: irq_enable_ext_one_q <= reg_wdata;
                `TLVI_IRQ_ENABLE_EXT_TWO_OFS: irq_enable_ext_two_q <= reg_wdata;
                `TLVI_IRQ_PRIORITY_BASE_OFS: irq_priority_base_reg_q <= {1'b0, reg_wdata[6:0]};
                `TLVI_IRQ_PRIORITY_EXT_ONE_OFS: irq_priority_ext_one_q <= reg_wdata;
                `TLVI_IRQ_PRIORITY_EXT_TWO_OFS: irq_priority_ext_two_q <= reg_wdata;
                default:
                begin
                end
            endcase
        end
    end

    // Call sequencing toward the core
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= TLVI_IDLE;
            call_req <= 1'b0;
            call_vector <= `TLVI_RESET_VEC;
            hw_flag_clear <= '0;
            call_idx_q <= '0;
            call_high_q <= 1'b0;
        end
        else
        begin
            hw_flag_clear <= hw_clr;
            unique case (state_q)
                TLVI_IDLE:
                begin
                    if (return_from_irq)
                    begin
                        state_q <= TLVI_WAIT_INSN;
                    end
                    else if (win_valid)
                    begin
                        state_q <= TLVI_CALL;
                        call_req <= 1'b1;
                        call_vector <= vec_of(win_idx);
                        call_idx_q <= win_idx;
                        call_high_q <= win_high;
                    end
                end
                TLVI_CALL:
                begin
                    if (call_ack)
                    begin
                        call_req <= 1'b0;
                        state_q <= TLVI_IDLE;
                    end
                end
                TLVI_WAIT_INSN:
                begin
                    if (insn_done)
                    begin
                        state_q <= TLVI_IDLE;
                    end
                end
                default:
                begin
                    state_q <= TLVI_IDLE;
                end
            endcase
        end
    end

    // Level in service; a return drops the innermost level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            in_low_q <= 1'b0;
            in_high_q <= 1'b0;
        end
        else if (state_q == TLVI_CALL && call_ack)
        begin
            if (call_high_q)
            begin
                in_high_q <= 1'b1;
            end
            else
            begin
                in_low_q <= 1'b1;
            end
        end
        else if (return_from_irq)
        begin
            if (in_high_q)
            begin
                in_high_q <= 1'b0;
            end
            else
            begin
                in_low_q <= 1'b0;
            end
        end
    end

    always_comb
    begin
        unique case (reg_addr)
            `TLVI_IRQ_BASE_REG_OFS: rdata_d = irq_enable_base_reg_q;
            `TLVI_IRQ_ENABLE_EXT_ONE_OFS: rdata_d = irq_enable_ext_one_q;
            `TLVI_IRQ_ENABLE_EXT_TWO_OFS: rdata_d = irq_enable_ext_two_q;
            `TLVI_IRQ_PRIORITY_BASE_OFS: rdata_d = irq_priority_base_reg_q | `TLVI_PRIO_BASE_UNUSED;
            `TLVI_IRQ_PRIORITY_EXT_ONE_OFS: rdata_d = irq_priority_ext_one_q;
            `TLVI_IRQ_PRIORITY_EXT_TWO_OFS: rdata_d = irq_priority_ext_two_q;
            `TLVI_STATUS_OFS: rdata_d = {3'h0, in_high_q, in_low_q, call_req, state_q};
            `TLVI_FLAG_LO_OFS: rdata_d = flag_q[7:0];
            `TLVI_FLAG_MID_OFS: rdata_d = flag_q[15:8];
            `TLVI_FLAG_HI_OFS: rdata_d = {1'b0, flag_q[NSRC-1:16]};
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end

endmodule // tlvi_unit

// ---- dv/tlvi_unit_monitor.sv ----
// Port checker for the interrupt unit
`timescale 1ns/1ps
module tlvi_unit_monitor
    import tlvi_pkg::*;
#(parameter int NSRC = 23)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register writes
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // Sources and core side
    input wire logic [NSRC-1:0] src_event,
    input wire logic call_ack,
    input wire logic return_from_irq,
    input wire logic insn_done,
    input wire logic call_req,
    input wire logic [15:0] call_vector,
    input wire logic [NSRC-1:0] hw_flag_clear
);
    // Own shadow of enables and nesting, so a stuck design register shows
    logic [23:0] en_q;
    logic [3:0] depth_q;
    logic ret_q;
    logic [NSRC-1:0] live;
    assign live = {en_q[23:8], en_q[6:0]} & src_event & ~23'h028000;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_q <= 24'h0;
            depth_q <= 4'h0;
            ret_q <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr < 8'h03)
                en_q[reg_addr[1:0]*8 +: 8] <= reg_wdata;
            depth_q <= depth_q + {3'h0, call_req & call_ack} - {3'h0, return_from_irq};
            ret_q <= return_from_irq | (ret_q & ~insn_done);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_fast_call:
        assert property (en_q[7] && |live && depth_q == 4'h0 && !call_req && !ret_q
            |-> ##[1:2] call_req) else $error("call late after event");
    a_req_hold:
        assert property (call_req && !call_ack |=> call_req && $stable(call_vector))
        else $error("request dropped or vector moved");
    a_ack_drop:
        assert property (call_req && call_ack |=> !call_req) else $error("request kept");
    a_vec_grid:
        assert property (call_req |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h00B3)
        else $error("vector off grid");
    a_clear_only:
        assert property (hw_flag_clear != 23'h0 |-> (hw_flag_clear & ~23'h01000F) == 23'h0
            && $past(call_req && call_ack)) else $error("wrong flag cleared");
    a_clear_ext:
        assert property (call_req && call_ack && call_vector == 16'h0003 |=> hw_flag_clear[0])
        else $error("input flag not cleared");
    a_global_gate:
        assert property ($rose(call_req) |-> $past(en_q[7])) else $error("call while off");
    a_ret_gap:
        assert property ($rose(call_req) |-> !$past(ret_q && !insn_done))
        else $error("call before next instruction");
    c_call: cover property (call_req && call_ack);
    c_ret: cover property (return_from_irq);
    c_clear: cover property (hw_flag_clear != 23'h0);
endmodule // tlvi_unit_monitor

bind tlvi_unit tlvi_unit_monitor #(.NSRC(NSRC)) tlvi_unit_monitor_i (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .src_event(src_event),
    .call_ack(call_ack),
    .return_from_irq(return_from_irq),
    .insn_done(insn_done),
    .call_req(call_req),
    .call_vector(call_vector),
    .hw_flag_clear(hw_flag_clear)
);

// ---- dv/tlvi_core_model.sv ----
// Core sequencer model: accepts calls, returns and runs one instruction
`timescale 1ns/1ps
module tlvi_core_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Unit side
    input wire logic call_req,
    output logic call_ack,
    output logic return_from_irq,
    output logic insn_done,
    // Bench side: accept delay, return command, next instruction length
    input wire logic [3:0] ack_dly,
    input wire logic ret_go,
    input wire logic [3:0] ins_dly
);
    logic [3:0] wait_q;
    logic [3:0] ins_q;
    logic go;
    assign go = call_req && !call_ack && wait_q == ack_dly;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_q <= 4'h0;
            ins_q <= 4'h0;
            call_ack <= 1'b0;
            return_from_irq <= 1'b0;
            insn_done <= 1'b0;
        end
        else
        begin
            // Slow accepts check that the request stands meanwhile
            call_ack <= go;
            wait_q <= (call_req && !call_ack && !go) ? wait_q + 4'h1 : 4'h0;
            return_from_irq <= ret_go;
            // A divide-length instruction models the slowest case
            insn_done <= ins_q == 4'h1;
            ins_q <= return_from_irq ? ins_dly : ins_q - {3'h0, ins_q != 4'h0};
        end
    end
endmodule // tlvi_core_model

// ---- dv/tlvi_unit_bench.sv ----
// Self-checking bench for the interrupt unit
`timescale 1ns/1ps
module tlvi_unit_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ret_go = 1'b0;
    logic rd_p = 1'b0;
    logic ack_p = 1'b0;
    logic [22:0] src_event = 23'h0;
    logic [22:0] src_level = 23'h0;
    logic [3:0] ack_dly = 4'h0;
    logic [3:0] ins_dly = 4'h1;
    logic [7:0] reg_rdata, rv;
    logic call_ack, return_from_irq, insn_done, call_req;
    logic [15:0] call_vector;
    logic [22:0] hw_flag_clear;
    logic [7:0] rq[$];
    logic [15:0] vq[$];
    logic [22:0] cq[$];
    int fail_count = 0;
    int n_tests = 0;
    int seed = 32'h49fbbd14;
    initial forever #12.5 clk = ~clk;
    tlvi_unit #(.NSRC(23)) tlvi_unit_i (
        .clk(clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .src_event(src_event),
        .src_level(src_level),
        .call_ack(call_ack),
        .return_from_irq(return_from_irq),
        .insn_done(insn_done),
        .call_req(call_req),
        .call_vector(call_vector),
        .hw_flag_clear(hw_flag_clear)
    );
    tlvi_core_model tlvi_core_model_i (
        .clk(clk),
        .rst(rst),
        .call_req(call_req),
        .call_ack(call_ack),
        .return_from_irq(return_from_irq),
        .insn_done(insn_done),
        .ack_dly(ack_dly),
        .ret_go(ret_go),
        .ins_dly(ins_dly)
    );
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_clr(input logic [22:0] e, input logic [22:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL at %0t exp %h got %h", $time, e, g);
        end
    endtask
    // Oldest note against each read answer and each accepted call
    always @(posedge clk)
    begin
        if (rd_p)
            chk({8'h00, rq.pop_front()}, {8'h00, reg_rdata});
        if (call_req && call_ack)
            chk(vq.pop_front(), call_vector);
        if (ack_p)
            chk_clr(cq.pop_front(), hw_flag_clear);
        rd_p <= reg_rd;
        ack_p <= call_req && call_ack;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (!w)
            rq.push_back(d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic ev(input logic [22:0] m);
        @(posedge clk);
        src_event <= m;
        @(posedge clk);
        src_event <= 23'h0;
    endtask
    task automatic take(input logic [15:0] v);
        int o;
        o = int'((v - 16'h0003) >> 3);
        vq.push_back(v);
        // Only the two inputs, timers 0 and 1 and CAN clear on vectoring
        cq.push_back((o < 4 || o == 16) ? 23'h1 << o : 23'h0);
        ack_dly <= 4'($unsigned($random(seed)) % 4);
        for (int i = 0; i < 40 && call_ack !== 1'b1; i++)
            @(negedge clk);
        @(posedge clk);
    endtask
    task automatic ret();
        @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
        for (int i = 0; i < 30 && insn_done !== 1'b1; i++)
            @(negedge clk);
        @(posedge clk);
    endtask
    task automatic quiet();
        repeat (8) @(negedge clk);
        chk(16'h0000, {15'h0, call_req});
        @(posedge clk);
    endtask
    task automatic complete_run();
        if (vq.size() != 0)
            fail_count++;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 8'h00, 8'h00);
        bus(1'b0, 8'h03, 8'h80);
        bus(1'b0, 8'h05, 8'h00);
        bus(1'b0, 8'hA5, 8'h00);
        rv = 8'($random(seed));
        bus(1'b1, 8'h01, rv);
        bus(1'b0, 8'h01, rv);
        $display("reset and map test done");
        bus(1'b1, 8'h00, 8'h10);
        bus(1'b1, 8'h07, 8'h10);
        quiet();
        bus(1'b0, 8'h07, 8'h10);
        bus(1'b1, 8'h00, 8'h90);
        take(16'h0023);
        bus(1'b1, 8'h07, 8'h00);
        ret();
        $display("software flag test done");
        bus(1'b1, 8'h00, 8'hFF);
        bus(1'b1, 8'h01, 8'hFF);
        bus(1'b1, 8'h02, 8'hFF);
        bus(1'b1, 8'h03, 8'h01);
        bus(1'b1, 8'h05, 8'h40);
        ev(23'h200208);
        take(16'h00AB);
        ev(23'h000001);
        quiet();
        bus(1'b1, 8'h09, 8'h00);
        ret();
        take(16'h0003);
        ret();
        take(16'h001B);
        bus(1'b0, 8'h07, 8'h00);
        quiet();
        ret();
        take(16'h004B);
        ev(23'h000001);
        take(16'h0003);
        ret();
        ins_dly <= 4'h8;
        ret();
        take(16'h004B);
        bus(1'b0, 8'h08, 8'h02);
        bus(1'b1, 8'h08, 8'h00);
        ret();
        ins_dly <= 4'h1;
        $display("priority test done");
        for (int k = 0; k < 23; k++)
        begin
            if (k == 15 || k == 17)
                src_level <= 23'h1 << k;
            else
                ev(23'h1 << k);
            take(16'h0003 + 16'(k) * 16'h0008);
            src_level <= 23'h0;
            bus(1'b1, 8'h07 + 8'(k / 8), 8'h00);
            ret();
        end
        $display("vector sweep test done");
        complete_run();
    end
endmodule // tlvi_unit_bench
